// file: rtl/fsw_pkg.sv
/*
 * Constants shared by the frame span node walker: link word layout,
 * type codes, word offsets and reset values.
 * Assumes a 32-bit system memory and a controller clock of 50 MHz.
 */
package fsw_pkg;

    // =========================================================
    // link word layout
    localparam int LINK_ADDR_MSB = 31;
    localparam int LINK_ADDR_LSB = 5;
    localparam int LINK_TYPE_MSB = 2;
    localparam int LINK_TYPE_LSB = 1;
    localparam int LINK_TERM_BIT = 0;

    // =========================================================
    // node word offsets within the frame span node
    localparam logic [31:0] NODE_FWD_OFS = 32'h0000_0000;
    localparam logic [31:0] NODE_BACK_OFS = 32'h0000_0004;

    // =========================================================
    // object type codes
    typedef enum logic [1:0] {
        FSW_TYP_ISO = 2'h0,
        FSW_TYP_QH = 2'h1,
        FSW_TYP_SITD = 2'h2,
        FSW_TYP_FSTN = 2'h3
    } fsw_typ_e;

    // =========================================================
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_SEGMENT = 32'h0000_0000;
    localparam logic [4:0] ALIGN_ZERO = 5'h00;

endpackage

// file: rtl/fsw_walker.sv
/*
 * Frame span node walker: fetches the two link words of a frame span
 * node from system memory, decodes them and reports the next object
 * and the save-place or restore marker.
 * Assumes a simple memory read port answering with a one-cycle
 * rdata valid strobe, and software-built nodes kept to their layout.
 */
// Overview of operation
// R01: software uses frame span nodes only for full/low speed frame-crossing work
// R02: software never links frame span nodes into the asynchronous schedule
// R03: software avoids frame span nodes below interface version 0x0096
// R04: first word bits 31..5 address the next periodic object
// R05: software writes zero into bits 4..3 of both link words
// R06: forward type decodes iso, queue head, split iso, frame span node
// R07: forward link valid when bit 0 clear, invalid when set
// R08: second word bits 31..5 address the back-path queue head
// R09: back terminate zero marks save-place, back address usable
// R10: back terminate one marks restore, back address never used
// R11: back type ignored whenever back terminate is one
// R12: software sets back type to the queue head code
// R13: link addresses combine with the upper address segment where applied
// R14: object fetches drive the low five address bits to zero
module fsw_walker
    import fsw_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // control
    input wire logic start_i,
    input wire logic [31:0] node_addr_i,
    input wire logic [31:0] upper_address_segment_i,
    input wire logic seg_en_i,
    // memory read master
    output logic mem_req_o,
    output logic [63:0] mem_addr_o,
    input wire logic mem_gnt_i,
    input wire logic mem_rvalid_i,
    input wire logic [31:0] mem_rdata_i,
    // decoded result
    output logic busy_o,
    output logic done_o,
    output logic fwd_valid_o,
    output logic [1:0] fwd_type_o,
    output logic [63:0] fwd_addr_o,
    output logic is_save_place_o,
    output logic is_restore_o,
    output logic back_valid_o,
    output logic [63:0] back_addr_o,
    output logic back_type_ok_o
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_REQ_FWD,
        ST_WAIT_FWD,
        ST_REQ_BACK,
        ST_WAIT_BACK,
        ST_RD_FWD,
        ST_DECODE
    } fsw_state_e;

    fsw_state_e state_q, state_d;
    logic [31:0] base_q;
    logic [31:0] seg_q;
    logic seg_en_q;
    logic [31:0] rd_word;
    logic [31:0] fwd_word_q;
    logic store_wr;
    logic store_sel;
    logic rd_sel;
    logic [31:0] fetch_lo;

    // forms a 64-bit object address from a link word
    function automatic logic [63:0] link_addr(input logic [31:0] word,
                                              input logic seg_en,
                                              input logic [31:0] seg);
        logic [63:0] a;
        // R13: segment combine
        a = {(seg_en ? seg : 32'h0000_0000), word[LINK_ADDR_MSB:LINK_ADDR_LSB], ALIGN_ZERO};
        return a;
    endfunction

    // =========================================================
    // word store
    assign store_wr = mem_rvalid_i && (state_q == ST_WAIT_FWD || state_q == ST_WAIT_BACK);
    assign store_sel = (state_q == ST_WAIT_BACK);
    // the store answers one edge after its select: the forward word is chosen
    // while the back word lands, the back word while the forward word is caught
    assign rd_sel = (state_q != ST_WAIT_BACK);

    fsw_word_store u_store (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .wr_en_i(store_wr),
        .wr_sel_i(store_sel),
        .wr_data_i(mem_rdata_i),
        .rd_sel_i(rd_sel),
        .rd_data_o(rd_word)
    );

    // =========================================================
    // memory request
    // node words sit 4 bytes apart; node itself is 32-byte aligned
    assign fetch_lo = (state_q == ST_REQ_BACK) ? (base_q + NODE_BACK_OFS)
                                               : (base_q + NODE_FWD_OFS);
    assign mem_req_o = (state_q == ST_REQ_FWD) || (state_q == ST_REQ_BACK);
    // R13: segment on fetches
    assign mem_addr_o = {(seg_en_q ? seg_q : 32'h0000_0000), fetch_lo};
    assign busy_o = (state_q != ST_IDLE);

    // =========================================================
    // sequencing
    // one read outstanding: the back fetch waits for the forward answer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_i) begin
                    state_d = ST_REQ_FWD;
                end
            end
            ST_REQ_FWD: begin
                if (mem_gnt_i) begin
                    state_d = ST_WAIT_FWD;
                end
            end
            ST_WAIT_FWD: begin
                if (mem_rvalid_i) begin
                    state_d = ST_REQ_BACK;
                end
            end
            ST_REQ_BACK: begin
                if (mem_gnt_i) begin
                    state_d = ST_WAIT_BACK;
                end
            end
            ST_WAIT_BACK: begin
                if (mem_rvalid_i) begin
                    state_d = ST_RD_FWD;
                end
            end
            ST_RD_FWD: begin
                state_d = ST_DECODE;
            end
            ST_DECODE: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // segment and base are caught at start so a walk sees one value
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            base_q <= RST_WORD;
            seg_q <= RST_SEGMENT;
            seg_en_q <= 1'b0;
        end else if (state_q == ST_IDLE && start_i) begin
            base_q <= {node_addr_i[31:5], ALIGN_ZERO};
            seg_q <= upper_address_segment_i;
            seg_en_q <= seg_en_i;
        end
    end

    // =========================================================
    // decode
    // in ST_RD_FWD the store presents the forward word, which is kept;
    // in ST_DECODE it presents the back word
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            fwd_word_q <= RST_WORD;
            done_o <= 1'b0;
            fwd_valid_o <= 1'b0;
            fwd_type_o <= FSW_TYP_ISO;
            fwd_addr_o <= 64'h0000_0000_0000_0000;
            is_save_place_o <= 1'b0;
            is_restore_o <= 1'b0;
            back_valid_o <= 1'b0;
            back_addr_o <= 64'h0000_0000_0000_0000;
            back_type_ok_o <= 1'b0;
        end else begin
            done_o <= (state_q == ST_DECODE);
            if (state_q == ST_RD_FWD) begin
                fwd_word_q <= rd_word;
            end
            if (state_q == ST_DECODE) begin
                // R07: forward terminate
                fwd_valid_o <= ~fwd_word_q[LINK_TERM_BIT];
                // R06: forward type decode
                fwd_type_o <= fwd_word_q[LINK_TYPE_MSB:LINK_TYPE_LSB];
                // R04: next object address
                // R14: aligned fetch
                fwd_addr_o <= link_addr(fwd_word_q, seg_en_q, seg_q);
                // R09: save-place marker
                is_save_place_o <= ~rd_word[LINK_TERM_BIT];
                // R10: restore marker
                is_restore_o <= rd_word[LINK_TERM_BIT];
                // R09: back link usable
                back_valid_o <= ~rd_word[LINK_TERM_BIT];
                // R08: back queue head address
                // R10: address withheld on restore
                // R14: aligned back fetch
                back_addr_o <= rd_word[LINK_TERM_BIT] ? 64'h0000_0000_0000_0000
                                                      : link_addr(rd_word, seg_en_q, seg_q);
                // R11: type ignored on restore
                back_type_ok_o <= rd_word[LINK_TERM_BIT] ? 1'b1
                    : (rd_word[LINK_TYPE_MSB:LINK_TYPE_LSB] == FSW_TYP_QH);
            end
        end
    end

endmodule

// file: rtl/fsw_word_store.sv
/*
 * Two-word store holding the fetched forward and back link words.
 * Read data comes out of a register, one cycle after the address.
 * Assumes a single clock, synchronous active-high reset.
 */
module fsw_word_store
    import fsw_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // write port
    input wire logic wr_en_i,
    input wire logic wr_sel_i,
    input wire logic [31:0] wr_data_i,
    // read port
    input wire logic rd_sel_i,
    output logic [31:0] rd_data_o
);

    logic [31:0] mem_q [2];

    // =========================================================
    // storage
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            mem_q[0] <= RST_WORD;
            mem_q[1] <= RST_WORD;
            rd_data_o <= RST_WORD;
        end else begin
            if (wr_en_i) begin
                mem_q[wr_sel_i] <= wr_data_i;
            end
            rd_data_o <= mem_q[rd_sel_i];
        end
    end

endmodule

// file: test/fsw_mem_model.sv
/* system memory holding one frame span node: word +0 and +4.
   assumes the walker keeps one read outstanding. */
module fsw_mem_model (
    // clock, reset, mode
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    // node contents
    input wire logic [31:0] fwd_word_i,
    input wire logic [31:0] back_word_i,
    // read slave
    input wire logic mem_req_i,
    input wire logic [63:0] mem_addr_i,
    output logic mem_gnt_o,
    output logic mem_rvalid_o,
    output logic [31:0] mem_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic t_q;
    // slow mode grants every other cycle to stall the walker
    assign mem_gnt_o = mem_req_i && (!slow_i || t_q);
    always_ff @(posedge mclk_i) begin
        t_q <= reset_i ? 1'b0 : ~t_q;
        mem_rvalid_o <= !reset_i && mem_gnt_o;
        // outside the answer the data lines invert each cycle, so stale data returns every other cycle
        mem_rdata_o <= mem_gnt_o ? (mem_addr_i[2] ? back_word_i : fwd_word_i) : ~mem_rdata_o;
    end
endmodule

// file: test/fsw_walker_asserts.sv
/* checker for fsw_walker: decode, marker and timing relations.
   assumes single clock mclk_i and sync reset_i; bound below. */
module fsw_walker_asserts
    import fsw_pkg::*;
(
    // ports watched
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic mem_req_o,
    input wire logic [63:0] mem_addr_o,
    input wire logic mem_rvalid_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic fwd_valid_o,
    input wire logic [1:0] fwd_type_o,
    input wire logic [63:0] fwd_addr_o,
    input wire logic is_save_place_o,
    input wire logic is_restore_o,
    input wire logic back_valid_o,
    input wire logic [63:0] back_addr_o,
    input wire logic back_type_ok_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    // =========================================
    // words seen: first answer forward, second back
    logic k_q;
    logic [31:0] f_q;
    logic [31:0] b_q;
    always_ff @(posedge mclk_i) begin
        if (reset_i) k_q <= 1'b0;
        else if (mem_rvalid_i) k_q <= ~k_q;
        if (mem_rvalid_i && !k_q) f_q <= mem_rdata_i;
        if (mem_rvalid_i && k_q) b_q <= mem_rdata_i;
    end
    sequence s_back_word;
        mem_rvalid_i && k_q;
    endsequence
    sequence s_result;
        done_o && !busy_o;
    endsequence
    // =========================================
    a_done_latency: assert property (s_back_word |-> ##3 s_result)
        else $error("done late");
    a_fwd_decode: assert property (done_o |->
        fwd_valid_o == !f_q[0] && fwd_type_o == f_q[2:1])
        else $error("forward decode");
    a_fwd_addr: assert property (done_o |->
        fwd_addr_o[31:0] == {f_q[31:5], ALIGN_ZERO})
        else $error("forward address");
    a_back_addr: assert property (done_o && !b_q[0] |->
        back_addr_o[31:0] == {b_q[31:5], 5'h00})
        else $error("back address");
    a_restore_no_addr: assert property (done_o && is_restore_o |-> back_addr_o == 64'h0)
        else $error("restore address used");
    a_marker_bit: assert property (done_o |->
        is_restore_o == b_q[0] && is_save_place_o == !b_q[0])
        else $error("marker decode");
    a_save_valid: assert property (done_o |-> back_valid_o == is_save_place_o)
        else $error("back valid");
    a_restore_type: assert property (done_o && is_restore_o |-> back_type_ok_o)
        else $error("type not ignored");
    a_fwd_align: assert property (done_o |->
        fwd_addr_o[4:0] == 5'h00 && back_addr_o[4:0] == 5'h00)
        else $error("unaligned");
    // forward word fetched first at offset 0, back word second at offset 4
    a_fetch_order: assert property (mem_req_o |->
        mem_addr_o[4:0] == (k_q ? 5'h04 : 5'h00))
        else $error("fetch order");
endmodule
bind fsw_walker fsw_walker_asserts u_chk (.mclk_i, .reset_i, .mem_req_o, .mem_addr_o,
    .mem_rvalid_i, .mem_rdata_i,
    .busy_o, .done_o, .fwd_valid_o, .fwd_type_o, .fwd_addr_o, .is_save_place_o,
    .is_restore_o, .back_valid_o, .back_addr_o, .back_type_ok_o);

// file: test/fsw_walker_tb.sv
/* self-checking bench for fsw_walker with a node memory model.
   assumes 50 MHz mclk_i and reset held five cycles. */
module fsw_walker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start = 1'b0, seg_en = 1'b0, slow = 1'b0;
    logic [31:0] fwd = 32'h0, back = 32'h0, seg = 32'h0;
    logic mem_req_o, mem_gnt_i, mem_rvalid_i, busy_o, done_o, fwd_valid_o;
    logic is_save_place_o, is_restore_o, back_valid_o, back_type_ok_o;
    logic [1:0] fwd_type_o;
    logic [31:0] mem_rdata_i;
    logic [63:0] mem_addr_o, fwd_addr_o, back_addr_o;
    int error_cnt = 0, checked = 0, cyc = 0;
    always #10 mclk_i = ~mclk_i;
    fsw_walker dut (.mclk_i, .reset_i, .start_i(start), .node_addr_i(32'h0000_1240),
        .upper_address_segment_i(seg), .seg_en_i(seg_en), .mem_req_o, .mem_addr_o,
        .mem_gnt_i, .mem_rvalid_i, .mem_rdata_i, .busy_o, .done_o, .fwd_valid_o,
        .fwd_type_o, .fwd_addr_o, .is_save_place_o, .is_restore_o, .back_valid_o,
        .back_addr_o, .back_type_ok_o);
    fsw_mem_model mem (.mclk_i, .reset_i, .slow_i(slow), .fwd_word_i(fwd),
        .back_word_i(back), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
        .mem_gnt_o(mem_gnt_i), .mem_rvalid_o(mem_rvalid_i), .mem_rdata_o(mem_rdata_i));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // =========================================
    // one walk, judged on the decoded outputs
    task automatic walk(input logic [31:0] f, b, s, input logic e, w);
        logic [31:0] hi;
        int n;
        hi = e ? s : 32'h0;
        fwd = f; back = b; seg = s; seg_en = e; slow = w; start = 1'b1;
        @(posedge mclk_i);
        #2 start = 1'b0;
        // done_o stands one cycle, so look once per cycle, off the edge
        for (n = 0; n < 40 && done_o !== 1'b1; n++) begin
            @(posedge mclk_i);
            #2;
        end
        cmp(done_o, 1'b1);
        cmp(fwd_addr_o, {hi, f[31:5], 5'h00});
        cmp({fwd_type_o, fwd_valid_o}, {f[2:1], !f[0]});
        cmp({is_restore_o, is_save_place_o, back_valid_o}, {b[0], !b[0], !b[0]});
        cmp(back_addr_o, b[0] ? 64'h0 : {hi, b[31:5], 5'h00});
        cmp(back_type_ok_o, b[0] | (b[2:1] == 2'h1));
        @(posedge mclk_i);
        #2;
    endtask
    task automatic t_types();
        for (int t = 0; t < 4; t++) walk(32'hABCD_E0E0 | (t << 1), 32'h1234_5662, 32'h0, 1'b0, 1'b0);
        $display("t_types done");
    endtask
    task automatic t_restore_seg();
        walk(32'hFFFF_FFE2, 32'h7777_77E5, 32'h0000_00A5, 1'b1, 1'b1);
        walk(32'h0000_0021, 32'hFFFF_FFE2, 32'hFFFF_FFFF, 1'b1, 1'b1);
        $display("t_restore_seg done");
    endtask
    task automatic t_reset_mid();
        fwd = 32'h0000_0042; start = 1'b1;
        repeat (3) @(posedge mclk_i);
        #2 start = 1'b0;
        reset_i = 1'b1;
        @(posedge mclk_i);
        #2;
        cmp({busy_o, mem_req_o, done_o, fwd_valid_o}, 4'h0);
        reset_i = 1'b0;
        walk(32'h0000_0102, 32'h0000_0203, 32'h0, 1'b0, 1'b0);
        $display("t_reset_mid done");
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge mclk_i);
        #2 reset_i = 1'b0;
        t_types();
        t_restore_seg();
        t_reset_mid();
        finish_test();
    end
endmodule
